// ### src/lnb_i2c_pkg.sv
package lnb_i2c_pkg;

   // bus address of this port, upper seven bits of the first byte
   localparam logic [6:0] LNB_SLAVE_ADDR  = 7'h08;
   // bus rates the port keeps up with, in kbit per second
   localparam int         LNB_STD_KBPS    = 100;
   localparam int         LNB_FAST_KBPS   = 400;
   localparam int         LNB_CLK_KHZ     = 40000;
   // system clock cycles in one fast-mode bit, sets the sampling margin
   localparam int         LNB_FAST_BIT_CYC = LNB_CLK_KHZ / LNB_FAST_KBPS;

   // register select bit of a written byte, and reset value of both registers
   localparam int         LNB_SEL_BIT     = 7;
   localparam logic [7:0] LNB_REG_RESET   = 8'h00;

   // channel1_control layout
   localparam int LNB_R1_DYN   = 6;
   localparam int LNB_R1_ISEL  = 5;
   localparam int LNB_R1_TONE  = 4;
   localparam int LNB_R1_COMP  = 3;
   localparam int LNB_R1_VSEL  = 2;
   localparam int LNB_R1_EN    = 1;
   localparam int LNB_R1_OLF   = 0;
   // channel2_control_status layout
   localparam int LNB_R2_ISEL  = 6;
   localparam int LNB_R2_TONE  = 5;
   localparam int LNB_R2_COMP  = 4;
   localparam int LNB_R2_VSEL  = 3;
   localparam int LNB_R2_EN    = 2;
   localparam int LNB_R2_HOT   = 1;
   localparam int LNB_R2_OLF   = 0;
   // read-only bits in each register image
   localparam logic [7:0] LNB_R1_RO_MASK = 8'h01;
   localparam logic [7:0] LNB_R2_RO_MASK = 8'h03;

   // protocol state of the serial slave
   typedef enum logic [2:0] {
      LNB_IDLE,
      LNB_ADDR,
      LNB_ADDR_ACK,
      LNB_WR_DATA,
      LNB_WR_ACK,
      LNB_RD_DATA,
      LNB_RD_ACK,
      LNB_IGNORE
   } lnb_state_t;

   // decoded output voltage level
   typedef enum logic [1:0] {
      LNB_V13,
      LNB_V14,
      LNB_V18,
      LNB_V19
   } lnb_volt_t;

   // decoded controls for one regulator channel
   typedef struct packed {
      logic      power_on;
      lnb_volt_t volt;
      logic      tone_on;
      logic      current_level_sel;
      logic      dynamic_limit_disable;
   } lnb_chan_t;

   // protection status inputs
   typedef struct packed {
      logic ch1_overload_flag;
      logic ch2_overload_flag;
      logic overtemp_flag;
   } lnb_status_t;

endpackage : lnb_i2c_pkg

// ### src/lnb_i2c_bit_capture.sv
`timescale 1ns/1ps
// link side: samples the data line on each rising edge of the bus clock.
// the value stays put for a whole bit, the system side reads it only
// after it has seen the same rising edge through its own synchroniser.
module lnb_i2c_bit_capture
   import lnb_i2c_pkg::*;
(
   input  wire logic scl_clk_i,
   input  wire logic sda_i,
   output logic      bit_o
);

   logic bit_q;

   // sample while the clock is high, data is stable then
   always_ff @(posedge scl_clk_i) begin
      bit_q <= sda_i;
   end

   assign bit_o = bit_q;

endmodule : lnb_i2c_bit_capture

// ### src/lnb_i2c_port.sv
`timescale 1ns/1ps
// How it works
// - data line driven open-drain only
// - runs at 100 or 400 kbit rates
// - data changes only while clock low
// - falling data, clock high: start
// - rising data, clock high: stop
// - eight bits msb first, then ack
// - ack holds data low through pulse
// - acknowledge every byte addressed to us
// - no acknowledge while power-good low
// - first byte: address then direction bit
// - start, address, data, ack, stop
// - both registers cleared at power-on
// - data msb picks target register
// - flag bits read-only, reflect status
// - voltage decoded from select and compensation
// - tone bit forces tone, else gate pin
// - current level and limit mode bits
// - enable low shuts channel regardless
// - read shifts msb first, nack ends
// - power-good low: ignore bus, zero registers
module lnb_i2c_port
   import lnb_i2c_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  srst_i,
   input  wire logic  scl_clk_i,
   input  wire logic  sda_i,
   output logic       sda_o,
   output logic       sda_oe_o,
   input  wire logic  power_good_i,
   input  wire logic  ch1_tone_gate_in_i,
   input  wire logic  ch2_tone_gate_in_i,
   input  lnb_status_t status_i,
   output lnb_chan_t  ch1_o,
   output lnb_chan_t  ch2_o,
   output logic [7:0] channel1_control_o,
   output logic [7:0] channel2_control_status_o
);

   lnb_state_t  state_q;
   logic [2:0]  scl_sync_q;
   logic [2:0]  sda_sync_q;
   logic [1:0]  pg_sync_q;
   logic [1:0]  gate1_sync_q;
   logic [1:0]  gate2_sync_q;
   lnb_status_t st_sync1_q;
   lnb_status_t st_sync2_q;
   logic        link_bit;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_ev;
   logic        stop_ev;
   logic        pg;
   logic [3:0]  cnt_q;
   logic [7:0]  rx_q;
   logic [7:0]  tx_q;
   logic        rd_next_q;
   logic        rw_q;
   logic        more_q;
   logic        sda_oe_q;
   logic        sda_q;
   logic [7:0]  reg1_q;
   logic [7:0]  reg2_q;
   logic [7:0]  rx_byte;
   logic [7:0]  image1;
   logic [7:0]  image2;
   lnb_chan_t   ch1_q;
   lnb_chan_t   ch2_q;
   logic [7:0]  ch1_reg_q;
   logic [7:0]  ch2_reg_q;

   // link clock domain: data bit capture
   // the captured bit is read only after the synchronised rising edge, when
   // it has settled for two clocks; it then holds until the next rise
   // one bit per bus clock rise
   lnb_i2c_bit_capture u_capture (
      .scl_clk_i (scl_clk_i),
      .sda_i     (sda_i),
      .bit_o     (link_bit)
   );

   // two-stage synchronisers, a third stage only for edge finding
   // a fast-mode bit spans LNB_FAST_BIT_CYC clocks, far more than the three
   // that the edge finder needs, so either bus rate is seen bit by bit
   // clock and data reset to their idle high level: no false edge after reset
   // both bus rates
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_sync_q   <= 3'h7;
         sda_sync_q   <= 3'h7;
         pg_sync_q    <= 2'h0;
         gate1_sync_q <= 2'h0;
         gate2_sync_q <= 2'h0;
         st_sync1_q   <= '0;
         st_sync2_q   <= '0;
      end else begin
         scl_sync_q   <= {scl_sync_q[1:0], scl_clk_i};
         sda_sync_q   <= {sda_sync_q[1:0], sda_i};
         pg_sync_q    <= {pg_sync_q[0], power_good_i};
         gate1_sync_q <= {gate1_sync_q[0], ch1_tone_gate_in_i};
         gate2_sync_q <= {gate2_sync_q[0], ch2_tone_gate_in_i};
         st_sync1_q   <= status_i;
         st_sync2_q   <= st_sync1_q;
      end
   end

   // bus events seen through the synchronisers
   assign pg       = pg_sync_q[1];
   assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
   assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
   // both events want the clock high in both stages, so a data change that
   // races a clock edge can not pass for a start or a stop
   // start and stop detection
   assign start_ev = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_sync_q[1];
   assign stop_ev  = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_sync_q[1];

   // byte being completed by the current bit
   // the incoming bit is not in rx_q yet on the edge that completes a byte
   assign rx_byte = {rx_q[6:0], link_bit};

   // flags follow the status pins two clocks late and are never stored
   // read images: flags come from status, not from storage
   always_comb begin
      image1 = reg1_q & ~LNB_R1_RO_MASK;
      image2 = reg2_q & ~LNB_R2_RO_MASK;
      image1[LNB_R1_OLF] = st_sync2_q.ch1_overload_flag;
      image2[LNB_R2_HOT] = st_sync2_q.overtemp_flag;
      image2[LNB_R2_OLF] = st_sync2_q.ch2_overload_flag;
      image2[LNB_SEL_BIT] = 1'b1;
   end

   // protocol sequencer
   // power loss, stop and start outrank the byte engine, so a cut frame
   // always brings the engine back to a known state
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q   <= LNB_IDLE;
         cnt_q     <= 4'h0;
         rx_q      <= 8'h00;
         tx_q      <= 8'h00;
         rw_q      <= 1'b0;
         more_q    <= 1'b0;
         rd_next_q <= 1'b0;
         sda_oe_q  <= 1'b0;
      // locked out while power is bad
      end else if (!pg) begin
         state_q   <= LNB_IDLE;
         cnt_q     <= 4'h0;
         rd_next_q <= 1'b0;
         sda_oe_q  <= 1'b0;
      end else if (stop_ev) begin
         state_q  <= LNB_IDLE;
         sda_oe_q <= 1'b0;
      end else if (start_ev) begin
         state_q   <= LNB_ADDR;
         cnt_q     <= 4'h0;
         rd_next_q <= 1'b0;
         sda_oe_q  <= 1'b0;
      end else begin
         unique case (state_q)
            // wrong address or read ended: sit out until a start or stop
            LNB_IDLE, LNB_IGNORE: begin
               sda_oe_q <= 1'b0;
            end
            LNB_ADDR: begin
               if (scl_rise && cnt_q < 4'h8) begin
                  rx_q  <= rx_byte;
                  cnt_q <= cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == 4'h8) begin
                  if (rx_q[7:1] == LNB_SLAVE_ADDR) begin
                     rw_q     <= rx_q[0];
                     sda_oe_q <= 1'b1;
                     state_q  <= LNB_ADDR_ACK;
                  end else begin
                     state_q <= LNB_IGNORE;
                  end
               end
            end
            LNB_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     tx_q      <= rd_next_q ? image2 : image1;
                     sda_oe_q  <= ~(rd_next_q ? image2[7] : image1[7]);
                     state_q   <= LNB_RD_DATA;
                  end else begin
                     sda_oe_q <= 1'b0;
                     state_q  <= LNB_WR_DATA;
                  end
               end
            end
            LNB_WR_DATA: begin
               if (scl_rise && cnt_q < 4'h8) begin
                  rx_q  <= rx_byte;
                  cnt_q <= cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == 4'h8) begin
                  sda_oe_q <= 1'b1;
                  state_q  <= LNB_WR_ACK;
               end
            end
            // ack released on the ninth fall, ready for the next byte
            LNB_WR_ACK: begin
               if (scl_fall) begin
                  sda_oe_q <= 1'b0;
                  cnt_q    <= 4'h0;
                  state_q  <= LNB_WR_DATA;
               end
            end
            // next bit goes out on the falling edge that ends this one
            // shift out msb first
            LNB_RD_DATA: begin
               if (scl_rise && cnt_q < 4'h8) begin
                  cnt_q <= cnt_q + 4'h1;
               end
               if (scl_fall) begin
                  if (cnt_q == 4'h8) begin
                     sda_oe_q <= 1'b0;
                     state_q  <= LNB_RD_ACK;
                  end else begin
                     sda_oe_q <= ~tx_q[3'h7 - cnt_q[2:0]];
                  end
               end
            end
            // master answer taken at the ninth rise, acted on at the ninth fall
            // master ack asks for more
            LNB_RD_ACK: begin
               if (scl_rise) begin
                  more_q <= ~link_bit;
               end
               if (scl_fall) begin
                  cnt_q <= 4'h0;
                  if (more_q) begin
                     tx_q      <= rd_next_q ? image1 : image2;
                     sda_oe_q  <= ~(rd_next_q ? image1[7] : image2[7]);
                     rd_next_q <= ~rd_next_q;
                     state_q   <= LNB_RD_DATA;
                  end else begin
                     state_q <= LNB_IGNORE;
                  end
               end
            end
         endcase
      end
   end

   // register storage
   // a byte lands at its eighth rise, before the ack slot, so a master that
   // never looks at the ack still updates the register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg1_q <= LNB_REG_RESET;
         reg2_q <= LNB_REG_RESET;
      // held at zero while power is bad
      end else if (!pg) begin
         reg1_q <= LNB_REG_RESET;
         reg2_q <= LNB_REG_RESET;
      end else if (state_q == LNB_WR_DATA && !start_ev && !stop_ev
                   && scl_rise && cnt_q == 4'h7) begin
         if (rx_byte[LNB_SEL_BIT]) begin
            reg2_q <= rx_byte & ~LNB_R2_RO_MASK;
         end else begin
            reg1_q <= rx_byte & ~LNB_R1_RO_MASK;
         end
      end
   end

   // channel decode, registered onto the outputs
   // register 2 has no limit-mode bit: both channels share register 1 bit 6
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ch1_q <= '0;
         ch2_q <= '0;
      end else begin
         ch1_q.power_on <= reg1_q[LNB_R1_EN];
         ch2_q.power_on <= reg2_q[LNB_R2_EN];
         ch1_q.volt <= !reg1_q[LNB_R1_EN] ? LNB_V13 :
                       lnb_volt_t'({reg1_q[LNB_R1_VSEL], reg1_q[LNB_R1_COMP]});
         ch2_q.volt <= !reg2_q[LNB_R2_EN] ? LNB_V13 :
                       lnb_volt_t'({reg2_q[LNB_R2_VSEL], reg2_q[LNB_R2_COMP]});
         ch1_q.tone_on <= reg1_q[LNB_R1_EN] & (reg1_q[LNB_R1_TONE] | gate1_sync_q[1]);
         ch2_q.tone_on <= reg2_q[LNB_R2_EN] & (reg2_q[LNB_R2_TONE] | gate2_sync_q[1]);
         ch1_q.current_level_sel     <= reg1_q[LNB_R1_EN] & reg1_q[LNB_R1_ISEL];
         ch2_q.current_level_sel     <= reg2_q[LNB_R2_EN] & reg2_q[LNB_R2_ISEL];
         ch1_q.dynamic_limit_disable <= reg1_q[LNB_R1_EN] & reg1_q[LNB_R1_DYN];
         ch2_q.dynamic_limit_disable <= reg2_q[LNB_R2_EN] & reg1_q[LNB_R1_DYN];
      end
   end

   // register images for observation
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ch1_reg_q <= LNB_REG_RESET;
         ch2_reg_q <= LNB_REG_RESET;
      end else begin
         ch1_reg_q <= image1;
         ch2_reg_q <= image2;
      end
   end

   // the drive value is fixed low; the line is let go by dropping the enable
   // open-drain: only ever drives low
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sda_q <= 1'b0;
      end else begin
         sda_q <= 1'b0;
      end
   end

   assign sda_o                     = sda_q;
   assign sda_oe_o                  = sda_oe_q;
   assign ch1_o                     = ch1_q;
   assign ch2_o                     = ch2_q;
   assign channel1_control_o        = ch1_reg_q;
   assign channel2_control_status_o = ch2_reg_q;

endmodule : lnb_i2c_port

// ### bench/lnb_i2c_port_checker.sv
`timescale 1ns/1ps
module lnb_i2c_port_checker
   import lnb_i2c_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic        scl_clk_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic        power_good_i,
   input wire lnb_status_t status_i,
   input wire lnb_chan_t   ch1_o,
   input wire lnb_chan_t   ch2_o,
   input wire logic [7:0]  channel1_control_o,
   input wire logic [7:0]  channel2_control_status_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);

   chk_drive_low: assert property (!sda_o)
      else $error("data line driven high");
   chk_oe_clk_low: assert property ($changed(sda_oe_o) |-> !scl_clk_i)
      else $error("data drive moved while clock high");
   // helper: clock falls seen while the port pulls the data line low
   logic       scl_seen_q;
   logic [3:0] held_falls_q;
   always_ff @(posedge clk_i) begin
      scl_seen_q <= scl_clk_i;
      if (srst_i || !sda_oe_o) begin
         held_falls_q <= 4'h0;
      end else if (scl_seen_q && !scl_clk_i) begin
         held_falls_q <= held_falls_q + 4'h1;
      end
   end
   // an ack followed by a read byte of zeros spans nine falls, at any bus rate
   chk_ack_bound: assert property (held_falls_q <= 4'h9)
      else $error("data line held low too long");
   chk_pg_no_ack: assert property (!power_good_i [*6] |-> !sda_oe_o)
      else $error("drive while power not good");
   chk_pg_clear: assert property (!power_good_i [*6] |-> ch1_o == '0 && ch2_o == '0
      && channel1_control_o[7:1] == 7'h00) else $error("registers not cleared");
   chk_ch1_off: assert property (!ch1_o.power_on |-> ch1_o == '0)
      else $error("channel 1 controls while off");
   chk_ch2_off: assert property (!ch2_o.power_on |-> ch2_o == '0)
      else $error("channel 2 controls while off");
   chk_volt_map: assert property ($stable(channel1_control_o) [*3] ##0 channel1_control_o[LNB_R1_EN]
      |-> ch1_o.volt == lnb_volt_t'({channel1_control_o[LNB_R1_VSEL], channel1_control_o[LNB_R1_COMP]}))
      else $error("voltage decode wrong");
   chk_tone_force: assert property ($stable(channel2_control_status_o) [*3]
      ##0 (channel2_control_status_o[LNB_R2_EN] && channel2_control_status_o[LNB_R2_TONE]) |-> ch2_o.tone_on)
      else $error("tone not forced on");
   chk_cur_sel: assert property ($stable(channel1_control_o) [*3] ##0 channel1_control_o[LNB_R1_EN]
      |-> ch1_o.current_level_sel == channel1_control_o[LNB_R1_ISEL]
      && ch1_o.dynamic_limit_disable == channel1_control_o[LNB_R1_DYN]) else $error("limit bits wrong");
   chk_flag_live: assert property (($stable(status_i) && power_good_i) [*5]
      |-> channel1_control_o[LNB_R1_OLF] == status_i.ch1_overload_flag
      && channel2_control_status_o[1:0] == {status_i.overtemp_flag, status_i.ch2_overload_flag})
      else $error("flags not following status");
endmodule : lnb_i2c_port_checker

bind lnb_i2c_port lnb_i2c_port_checker u_chk (.clk_i(clk_i), .srst_i(srst_i), .scl_clk_i(scl_clk_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .power_good_i(power_good_i), .status_i(status_i), .ch1_o(ch1_o),
   .ch2_o(ch2_o), .channel1_control_o(channel1_control_o), .channel2_control_status_o(channel2_control_status_o));

// ### bench/lnb_host_model.sv
`timescale 1ns/1ps
// bus master in the host's place; clock idles high between frames
module lnb_host_model (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   initial begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic wt(int n);
      repeat (n) @(negedge clk_i);
   endtask : wt
   task automatic start;
      sda_oe_o = 1'b1;
      wt(6);
      scl_o = 1'b0;
      wt(3);
   endtask : start
   // data rises while clock high, bus left free
   task automatic stop;
      sda_oe_o = 1'b1;
      wt(3);
      scl_o = 1'b1;
      wt(6);
      sda_oe_o = 1'b0;
      wt(12);
   endtask : stop
   // one pulse a bit, data set mid-low
   task automatic xbit(input logic b, output logic r);
      sda_oe_o = ~b;
      wt(3);
      scl_o = 1'b1;
      wt(3);
      r = sda_i;
      wt(3);
      scl_o = 1'b0;
      wt(3);
   endtask : xbit
   // eight bits msb first, then ack pulse
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(a, r);
   endtask : xbyte
endmodule : lnb_host_model

// ### bench/lnb_i2c_port_tb.sv
`timescale 1ns/1ps
module lnb_i2c_port_tb;
   import lnb_i2c_pkg::*;
   logic        clk_i, srst_i, power_good_i, g1, g2, scl, h_oe, d_o, d_oe, ak;
   wire         sda = ~(d_oe | h_oe);
   lnb_status_t st;
   lnb_chan_t   c1, c2;
   logic [7:0]  im1, im2, r1, r2, q;
   logic [15:0] rnd;
   logic [7:0]  cor [7] = '{8'h02, 8'h06, 8'h0a, 8'h0e, 8'h7d, 8'hff, 8'h84};
   int          fails, n_checks;

   lnb_i2c_port u_dut (.clk_i(clk_i), .srst_i(srst_i), .scl_clk_i(scl), .sda_i(sda), .sda_o(d_o),
      .sda_oe_o(d_oe), .power_good_i(power_good_i), .ch1_tone_gate_in_i(g1), .ch2_tone_gate_in_i(g2),
      .status_i(st), .ch1_o(c1), .ch2_o(c2), .channel1_control_o(im1), .channel2_control_status_o(im2));
   lnb_host_model u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // f = {current sel, tone, comp, high volt, power on}
   function automatic lnb_chan_t exp_ch(logic [4:0] f, logic g, logic dl);
      lnb_chan_t c;
      c = '0;
      if (f[0]) c = '{1'b1, lnb_volt_t'({f[1], f[2]}), f[3] | g, f[4], dl};
      return c;
   endfunction : exp_ch
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk_ch(string nm, lnb_chan_t e, lnb_chan_t g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %b got %b", nm, e, g);
      end
   endtask : chk_ch
   // let registers and outputs land, then compare everything
   task automatic settle;
      repeat (6) @(negedge clk_i);
      chk8("image1", {1'b0, r1[6:1], st.ch1_overload_flag}, im1);
      chk8("image2", {1'b1, r2[6:2], st.overtemp_flag, st.ch2_overload_flag}, im2);
      chk_ch("chan1", exp_ch(r1[5:1], g1, r1[6]), c1);
      chk_ch("chan2", exp_ch(r2[6:2], g2, r1[6]), c2);
   endtask : settle
   // one write frame; ea says whether the port should answer
   task automatic wr(logic [6:0] a, logic [7:0] ds[$], logic ea);
      u_host.start;
      u_host.xbyte({a, 1'b0}, 1'b1, q, ak);
      chk8("addr ack", {7'h0, ~ea}, {7'h0, ak});
      foreach (ds[k]) begin
         u_host.xbyte(ds[k], 1'b1, q, ak);
         chk8("data ack", {7'h0, ~ea}, {7'h0, ak});
         if (ea && ds[k][7]) r2 = ds[k];
         else if (ea) r1 = ds[k];
      end
      u_host.stop;
   endtask : wr
   // read image1, image2 and image1 again; nack after the third
   task automatic rd;
      u_host.start;
      u_host.xbyte({LNB_SLAVE_ADDR, 1'b1}, 1'b1, q, ak);
      chk8("rd ack", 8'h00, {7'h0, ak});
      u_host.xbyte(8'hff, 1'b0, q, ak);
      chk8("rd image1", {1'b0, r1[6:1], st.ch1_overload_flag}, q);
      u_host.xbyte(8'hff, 1'b0, q, ak);
      chk8("rd image2", {1'b1, r2[6:2], st.overtemp_flag, st.ch2_overload_flag}, q);
      u_host.xbyte(8'hff, 1'b1, q, ak);
      chk8("rd image1 again", {1'b0, r1[6:1], st.ch1_overload_flag}, q);
      u_host.stop;
   endtask : rd

   // watchdog against a hung run
   initial begin
      repeat (100000) @(posedge clk_i);
      fails++;
      close_out;
   end

   initial begin
      srst_i = 1'b1;
      power_good_i = 1'b1;
      {g1, g2, st} = 5'h00;
      {r1, r2} = 16'h0000;
      rnd = 16'd24801;
      repeat (4) @(negedge clk_i);
      srst_i = 1'b0;
      settle;
      foreach (cor[k]) begin
         wr(LNB_SLAVE_ADDR, '{cor[k]}, 1'b1);
         settle;
      end
      wr(LNB_SLAVE_ADDR, '{8'h13, 8'hfd}, 1'b1);
      settle;
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         wr(LNB_SLAVE_ADDR, '{rnd[7:0]}, 1'b1);
         {g1, g2, st} = rnd[12:8];
         settle;
         if (i % 4 == 0) rd;
      end
      wr(LNB_SLAVE_ADDR ^ 7'h01, '{8'h3e}, 1'b0);
      settle;
      // power loss: registers cleared, bus ignored
      st = '0;
      power_good_i = 1'b0;
      {r1, r2} = 16'h0000;
      settle;
      wr(LNB_SLAVE_ADDR, '{8'h1e}, 1'b0);
      settle;
      power_good_i = 1'b1;
      repeat (8) @(negedge clk_i);
      wr(LNB_SLAVE_ADDR, '{8'h9e}, 1'b1);
      settle;
      rd;
      close_out;
   end
endmodule : lnb_i2c_port_tb
